// ---- rtl/ubic_config.sv ----
// baud divisor, auto-baud window, debug halt and infrared shaping
//
// The plain strobed port was decided locally.
module ubic_config (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire ubic_pkg::ubic_bus_t bus,
  output logic [7:0]             rd_data,
  input  wire logic              debug_halt,
  input  wire logic              tx_data,
  input  wire logic              ir_rx_pin,
  input  wire logic              event_rx,
  input  wire logic              sync_edge,
  output logic                   ir_tx,
  output logic                   rx_data,
  output logic                   sample_tick,
  output logic                   baud_clock,
  output logic                   autobaud_ok,
  output logic                   autobaud_err,
  output logic                   halted
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0]          divisor;
  logic [1:0]           autobaud_window_size;
  logic                 run_while_halted;
  logic                 infrared_event_input_enable;
  logic [7:0]           tx_pulse_length;
  logic [6:0]           rx_filter_length;
  ubic_pkg::ubic_mode_t mode;
  logic                 last_ok;
  logic                 last_err;

  logic wr_lo;
  logic wr_hi;
  logic wr_div;
  logic stop;
  logic ir_on;
  logic coded;
  logic bit_edge;

  assign wr_lo  = bus.wr && bus.addr == ubic_pkg::OFS_DIV_LO;
  assign wr_hi  = bus.wr && bus.addr == ubic_pkg::OFS_DIV_HI;
  assign wr_div = wr_lo || wr_hi;
  assign stop   = debug_halt && !run_while_halted;
  assign ir_on  = mode.communication_mode == ubic_pkg::COMMUNICATION_MODE_IR;
  assign coded  = ir_on && tx_pulse_length != ubic_pkg::TX_PULSE_LENGTH_OFF;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      divisor <= ubic_pkg::RST_DIV;
    else if (wr_lo)
      divisor[7:0] <= bus.wdata;
    else if (wr_hi)
      divisor[15:8] <= bus.wdata;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      autobaud_window_size        <= 2'h0;
      run_while_halted            <= 1'b0;
      infrared_event_input_enable <= 1'b0;
      tx_pulse_length             <= ubic_pkg::RST_BYTE;
      rx_filter_length            <= 7'h00;
      mode                        <= '0;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        ubic_pkg::OFS_WINDOW:
          autobaud_window_size <= bus.wdata[ubic_pkg::WINDOW_LSB +: 2];
        ubic_pkg::OFS_DEBUG:
          run_while_halted <= bus.wdata[0];
        ubic_pkg::OFS_EVENT:
          infrared_event_input_enable <= bus.wdata[0];
        ubic_pkg::OFS_TX_PULSE_LENGTH:
          tx_pulse_length <= bus.wdata;
        ubic_pkg::OFS_RX_FILTER_LENGTH:
          rx_filter_length <= bus.wdata[6:0];
        ubic_pkg::OFS_MODE:
        begin
          mode.communication_mode <= bus.wdata[ubic_pkg::COMMUNICATION_MODE_LSB +: 2];
          mode.receiver_mode      <= bus.wdata[ubic_pkg::RECEIVER_MODE_LSB +: 2];
          mode.transmitter_enable <= bus.wdata[ubic_pkg::TRANSMITTER_ENABLE_BIT];
          mode.receiver_enable    <= bus.wdata[ubic_pkg::RECEIVER_ENABLE_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = 8'h00;
    unique case (bus.addr)
      ubic_pkg::OFS_DIV_LO: next_rd_data = divisor[7:0];
      ubic_pkg::OFS_DIV_HI: next_rd_data = divisor[15:8];
      ubic_pkg::OFS_WINDOW:
        next_rd_data[ubic_pkg::WINDOW_LSB +: 2] = autobaud_window_size;
      ubic_pkg::OFS_DEBUG:  next_rd_data[0] = run_while_halted;
      ubic_pkg::OFS_EVENT:  next_rd_data[0] = infrared_event_input_enable;
      ubic_pkg::OFS_TX_PULSE_LENGTH:   next_rd_data = tx_pulse_length;
      ubic_pkg::OFS_RX_FILTER_LENGTH:   next_rd_data[6:0] = rx_filter_length;
      ubic_pkg::OFS_MODE:
      begin
        next_rd_data[ubic_pkg::COMMUNICATION_MODE_LSB +: 2]  = mode.communication_mode;
        next_rd_data[ubic_pkg::RECEIVER_MODE_LSB +: 2] = mode.receiver_mode;
        next_rd_data[ubic_pkg::TRANSMITTER_ENABLE_BIT]        = mode.transmitter_enable;
        next_rd_data[ubic_pkg::RECEIVER_ENABLE_BIT]        = mode.receiver_enable;
      end
      ubic_pkg::OFS_STATUS: next_rd_data[2:0] = {last_err, last_ok, halted};
      default:              next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rd_data <= 8'h00;
    else if (bus.rd)
      rd_data <= next_rd_data;
    else
      rd_data <= 8'h00;
  end

  // ---------------------------------------------------------------
  // baud prescaler: sample tick every divisor+1 clocks
  // ---------------------------------------------------------------
  logic [15:0] baud_cnt;
  logic [3:0]  sample_idx;
  logic [3:0]  next_sample_idx;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baud_cnt    <= ubic_pkg::RST_DIV;
      sample_tick <= 1'b0;
    end
    else if (wr_div)
    begin
      // new divisor takes over at once, frames in flight are lost
      baud_cnt    <= wr_lo ? {divisor[15:8], bus.wdata}
                           : {bus.wdata, divisor[7:0]};
      sample_tick <= 1'b0;
    end
    else if (stop)
      sample_tick <= 1'b0;
    else if (baud_cnt == 16'h0000)
    begin
      baud_cnt    <= divisor;
      sample_tick <= 1'b1;
    end
    else
    begin
      baud_cnt    <= baud_cnt - 16'h0001;
      sample_tick <= 1'b0;
    end
  end

  // sixteen samples per bit; the wrap is the baud clock rising edge
  always_comb
  begin
    next_sample_idx = sample_idx;
    if (wr_div)
      next_sample_idx = 4'h0;
    else if (sample_tick && !stop)
      next_sample_idx = sample_idx + 4'h1;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      sample_idx <= 4'h0;
    else
      sample_idx <= next_sample_idx;
  end

  assign bit_edge = sample_tick && !stop && sample_idx == ubic_pkg::LAST_SAMPLE;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baud_clock <= 1'b0;
      halted     <= 1'b0;
    end
    else
    begin
      // taken from the next index so the baud clock rises with a pulse start
      baud_clock <= next_sample_idx[3] == 1'b0;
      halted     <= stop;
    end
  end

  // ---------------------------------------------------------------
  // auto-baud window check
  // ---------------------------------------------------------------
  logic       lin_mode;
  logic [5:0] pair_cnt;
  logic       armed;
  logic       ab_eval;
  logic [5:0] tol;
  logic [5:0] dev;

  assign lin_mode = mode.receiver_mode == ubic_pkg::RECEIVER_MODE_LIN;
  assign ab_eval  = lin_mode && armed && sync_edge && !stop;
  assign dev      = pair_cnt > ubic_pkg::PAIR_NOM ? pair_cnt - ubic_pkg::PAIR_NOM
                                                  : ubic_pkg::PAIR_NOM - pair_cnt;

  always_comb
  begin
    unique case (autobaud_window_size)
      2'h0: tol = ubic_pkg::TOL_SIX;
      2'h1: tol = ubic_pkg::TOL_FIVE;
      2'h2: tol = ubic_pkg::TOL_SEVEN;
      2'h3: tol = ubic_pkg::TOL_EIGHT;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pair_cnt <= 6'h00;
      armed    <= 1'b0;
    end
    else if (!lin_mode)
    begin
      pair_cnt <= 6'h00;
      armed    <= 1'b0;
    end
    else if (sync_edge && !stop)
    begin
      pair_cnt <= 6'h00;
      armed    <= 1'b1;
    end
    else if (sample_tick && !stop && pair_cnt != ubic_pkg::PAIR_MAX)
      pair_cnt <= pair_cnt + 6'h01;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      autobaud_ok  <= 1'b0;
      autobaud_err <= 1'b0;
      last_ok      <= 1'b0;
      last_err     <= 1'b0;
    end
    else
    begin
      autobaud_ok  <= ab_eval && dev <= tol;
      autobaud_err <= ab_eval && dev > tol;
      if (ab_eval)
      begin
        last_ok  <= dev <= tol;
        last_err <= dev > tol;
      end
    end
  end

  // ---------------------------------------------------------------
  // infrared transmit pulse shaping
  // ---------------------------------------------------------------
  logic [7:0] pulse_left;
  logic       pulse_short;
  logic [7:0] next_pulse_left;
  logic       pulse_start;

  assign pulse_start = coded && mode.transmitter_enable && bit_edge && !tx_data;

  always_comb
  begin
    next_pulse_left = pulse_left;
    if (pulse_start)
      next_pulse_left = tx_pulse_length == ubic_pkg::TX_PULSE_LENGTH_3_16
                      ? ubic_pkg::SHORT_TICKS : tx_pulse_length;
    else if (!coded || !mode.transmitter_enable)
      // a pulse cut by a mode change must not reappear later off the edge
      next_pulse_left = 8'h00;
    else if (stop || pulse_left == 8'h00)
      next_pulse_left = pulse_left;
    else if (!pulse_short || sample_tick)
      next_pulse_left = pulse_left - 8'h01;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulse_left  <= 8'h00;
      pulse_short <= 1'b0;
    end
    else
    begin
      pulse_left <= next_pulse_left;
      if (pulse_start)
        pulse_short <= tx_pulse_length == ubic_pkg::TX_PULSE_LENGTH_3_16;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ir_tx <= 1'b0;
    else if (coded)
      ir_tx <= next_pulse_left != 8'h00;
    else
      ir_tx <= tx_data;
  end

  // ---------------------------------------------------------------
  // infrared receive path
  // ---------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic rx_raw;
  logic rx_filt;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= ir_rx_pin;
      pin_sync <= pin_meta;
    end
  end

  // events are dropped while frozen
  assign rx_raw = !infrared_event_input_enable ? event_rx && !stop
                                               : pin_sync;

  ubic_pulse_filter u_filter (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .sample_en (sample_tick),
    .raw       (rx_raw),
    .len       (coded ? rx_filter_length : 7'h00),
    .filt      (rx_filt)
  );

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rx_data <= 1'b1;
    else if (coded)
      rx_data <= !rx_filt;
    else
      rx_data <= rx_filt;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  hi_byte_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hi |=> (divisor[15:8] == $past(bus.wdata)))
    else $error("high divisor byte not stored");

  baud_reload_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_div |=> (baud_cnt == divisor && sample_idx == 4'h0))
    else $error("prescaler not reloaded on divisor write");

  halt_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
    (stop && !wr_div) |=> ($stable(baud_cnt) && !sample_tick))
    else $error("prescaler moved while halted");

  debug_run_a: assert property (@(posedge clock) disable iff (sys_rst)
    (debug_halt && run_while_halted && !wr_div && baud_cnt != 16'h0000)
      |=> (baud_cnt == $past(baud_cnt) - 16'h0001))
    else $error("prescaler stopped in debug run");

  window_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(lin_mode) |-> (!autobaud_ok && !autobaud_err))
    else $error("window result outside constrained mode");

  window_judge_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ab_eval && pair_cnt >= 6'h1a && pair_cnt <= 6'h26 && autobaud_window_size == 2'h0)
      |=> autobaud_ok)
    else $error("count within six rejected");

  event_source_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!infrared_event_input_enable && !stop) |-> (rx_raw == event_rx))
    else $error("event input not selected");

  fixed_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pulse_start && tx_pulse_length == 8'h04 && !debug_halt)
      |=> ir_tx [*4] ##1 !ir_tx)
    else $error("fixed pulse length wrong");

  pass_through_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ir_on && tx_pulse_length == ubic_pkg::TX_PULSE_LENGTH_OFF) |=> (ir_tx == $past(tx_data)))
    else $error("uncoded transmit not passed through");

  pulse_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    (coded && $rose(ir_tx)) |-> $past(bit_edge))
    else $error("pulse not aligned to baud clock");

endmodule

// ---- rtl/ubic_pkg.sv ----
// constants and types for the baud and infrared configuration block
package ubic_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DIV_LO  = 8'h08;
  localparam logic [7:0] OFS_DIV_HI  = 8'h09;
  localparam logic [7:0] OFS_WINDOW  = 8'h0a;
  localparam logic [7:0] OFS_DEBUG   = 8'h0b;
  localparam logic [7:0] OFS_EVENT   = 8'h0c;
  localparam logic [7:0] OFS_TX_PULSE_LENGTH    = 8'h0d;
  localparam logic [7:0] OFS_RX_FILTER_LENGTH    = 8'h0e;
  localparam logic [7:0] OFS_MODE    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h11;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         WINDOW_LSB  = 6;
  localparam int         COMMUNICATION_MODE_LSB   = 6;
  localparam int         RECEIVER_MODE_LSB  = 4;
  localparam int         TRANSMITTER_ENABLE_BIT    = 1;
  localparam int         RECEIVER_ENABLE_BIT    = 0;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIV    = 16'h0000;

  // ---------------------------------------------------------------
  // mode codes and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] COMMUNICATION_MODE_IR    = 2'h2;
  localparam logic [1:0] RECEIVER_MODE_LIN  = 2'h3;
  localparam logic [7:0] TX_PULSE_LENGTH_3_16   = 8'h00;
  localparam logic [7:0] TX_PULSE_LENGTH_OFF    = 8'hff;
  localparam logic [7:0] SHORT_TICKS = 8'h03;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [5:0] PAIR_NOM    = 6'h20;
  localparam logic [5:0] PAIR_MAX    = 6'h3f;
  localparam logic [5:0] TOL_SIX     = 6'h06;
  localparam logic [5:0] TOL_FIVE    = 6'h05;
  localparam logic [5:0] TOL_SEVEN   = 6'h07;
  localparam logic [5:0] TOL_EIGHT   = 6'h08;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ubic_bus_t;

  typedef struct packed {
    logic [1:0] communication_mode;
    logic [1:0] receiver_mode;
    logic       transmitter_enable;
    logic       receiver_enable;
  } ubic_mode_t;

endpackage

// ---- rtl/ubic_pulse_filter.sv ----
// receive pulse filter: accepts a level after len+1 equal samples
module ubic_pulse_filter (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       sample_en,
  input  wire logic       raw,
  input  wire logic [6:0] len,
  output logic            filt
);

  logic [6:0] run_cnt;

  // ---------------------------------------------------------------
  // filter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      filt    <= 1'b0;
      run_cnt <= 7'h00;
    end
    else if (len == 7'h00)
    begin
      filt    <= raw;
      run_cnt <= 7'h00;
    end
    else if (sample_en)
    begin
      if (raw == filt)
        run_cnt <= 7'h00;
      else if (run_cnt == len)
      begin
        filt    <= raw;
        run_cnt <= 7'h00;
      end
      else
        run_cnt <= run_cnt + 7'h01;
    end
  end

  filt_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    (len == 7'h00) |=> (filt == $past(raw)))
    else $error("unfiltered path does not follow input");

  filt_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (len != 7'h00 && $past(len) != 7'h00 && $past(filt) != filt) |-> $past(sample_en))
    else $error("filter changed without a sample");

endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the baud and infrared configuration block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  ubic_pkg::ubic_bus_t bus = '0;
  logic debug_halt = 1'b0, tx_data = 1'b0, event_rx = 1'b0, sync_edge = 1'b0;
  logic idle_lvl = 1'b0, tx_prev = 1'b0;
  logic [7:0] rd_data;
  logic ir_rx_pin, ir_tx, rx_data, sample_tick, baud_clock, autobaud_ok, autobaud_err, halted;
  logic [3:0] bc_hist = '0, rise_bc = '0;
  int failures = 0, compares = 0, last_w, n_pulse;

  always #4 clock = ~clock;

  ubic_config uut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
    .debug_halt(debug_halt), .tx_data(tx_data), .ir_rx_pin(ir_rx_pin),
    .event_rx(event_rx), .sync_edge(sync_edge), .ir_tx(ir_tx), .rx_data(rx_data),
    .sample_tick(sample_tick), .baud_clock(baud_clock), .autobaud_ok(autobaud_ok),
    .autobaud_err(autobaud_err), .halted(halted));

  ubic_ir_peer peer (.clock(clock), .ir_tx(ir_tx), .idle_lvl(idle_lvl),
    .ir_rx_pin(ir_rx_pin), .last_w(last_w), .n_pulse(n_pulse));

  // remembers the baud clock around each rise of the transmit line
  always @(posedge clock)
  begin
    bc_hist <= {bc_hist[2:0], baud_clock};
    tx_prev <= ir_tx;
    if (ir_tx && !tx_prev)
      rise_bc <= {bc_hist[2:0], baud_clock};
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task chk(input string n, input logic [15:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task bus_wr(input logic [7:0] a, d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  task bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rd_data;
  endtask

  task tick_wait(output int c);
    c = 0;
    do
    begin
      @(posedge clock);
      #1 c++;
    end
    while (sample_tick !== 1'b1 && c < 70000);
  endtask

  task ticks(output int c);
    c = 0;
    repeat (40)
    begin
      @(posedge clock);
      #1 c += sample_tick;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    logic [7:0] ofs [8];
    logic [7:0] msk [8];
    logic [7:0] v;
    ofs = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
    msk = '{8'hff, 8'hff, 8'hc0, 8'h01, 8'h01, 8'hff, 8'h7f, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      bus_rd(ofs[i], v);
      chk("reset value", v, 8'h00);
      bus_wr(ofs[i], 8'hff);
      bus_rd(ofs[i], v);
      chk("ones readback", v, msk[i]);
      bus_wr(ofs[i], 8'h00);
    end
    $display("test registers done");
  endtask

  task t_baud;
    int c;
    bus_wr(8'h08, 8'h04);
    tick_wait(c);
    tick_wait(c);
    chk("period low byte", c, 5);
    bus_wr(8'h09, 8'h01);
    tick_wait(c);
    tick_wait(c);
    chk("period both bytes", c, 261);
    bus_wr(8'h09, 8'hff);
    cyc(20);
    bus_wr(8'h09, 8'h00);
    tick_wait(c);
    chk("reload at write", c <= 8, 1);
    $display("test prescaler done");
  endtask

  task ab(input int n, input logic [1:0] w, rxm, exp);
    logic [1:0] res;
    int c;
    bus_wr(8'h10, 8'h00);
    bus_wr(8'h0a, {w, 6'h00});
    bus_wr(8'h10, {2'h0, rxm, 4'h0});
    tick_wait(c);
    @(posedge clock);
    sync_edge <= 1'b1;
    @(posedge clock);
    sync_edge <= 1'b0;
    cyc(2 * n - 1);
    sync_edge <= 1'b1;
    @(posedge clock);
    sync_edge <= 1'b0;
    res = 2'b00;
    // the verdict stands only in the cycle after the closing edge
    repeat (3)
    begin
      #1 res |= {autobaud_err, autobaud_ok};
      @(posedge clock);
    end
    chk("window verdict", res, exp);
  endtask

  task t_ab;
    int tol [4];
    tol = '{6, 5, 7, 8};
    bus_wr(8'h08, 8'h01);
    bus_wr(8'h09, 8'h00);
    for (int w = 0; w < 4; w++)
    begin
      ab(32 + tol[w], w[1:0], 2'h3, 2'b01);
      ab(31 - tol[w], w[1:0], 2'h3, 2'b10);
    end
    ab(32, 2'h0, 2'h2, 2'b00);
    $display("test auto-baud done");
  endtask

  task tx_case(input logic [7:0] pl);
    int c, n0;
    bus_wr(8'h10, 8'h00);
    bus_wr(8'h0d, pl);
    bus_wr(8'h10, 8'h83);
    n0 = n_pulse;
    c = 0;
    while (n_pulse < n0 + 2 && c < 3000)
    begin
      @(posedge clock);
      c++;
    end
    if (pl == 8'h00)
      chk("3/16 pulse", last_w >= 33 && last_w <= 63, 1);
    else
    begin
      chk("fixed pulse", last_w, pl);
      chk("pulse at baud edge", rise_bc[0] && rise_bc != 4'hf, 1);
    end
  endtask

  task t_tx;
    int n0;
    bus_wr(8'h08, 8'h0f);
    tx_case(8'h01);
    tx_case(8'h04);
    tx_case(8'hfe);
    tx_case(8'h00);
    bus_wr(8'h10, 8'h00);
    bus_wr(8'h0d, 8'hff);
    bus_wr(8'h10, 8'h83);
    tx_data <= 1'b1;
    cyc(3);
    #1 chk("ir copy high", ir_tx, 1);
    n0 = n_pulse;
    @(posedge clock);
    tx_data <= 1'b0;
    cyc(600);
    chk("no coded pulse", n_pulse - n0, 1);
    bus_wr(8'h10, 8'h00);
    bus_wr(8'h0d, 8'h05);
    bus_wr(8'h10, 8'h03);
    n0 = n_pulse;
    cyc(600);
    chk("no pulse outside infrared", n_pulse - n0, 0);
    $display("test transmit shaping done");
  endtask

  task rx_case(input logic [6:0] pl, input int len, input logic exp);
    logic seen;
    bus_wr(8'h10, 8'h00);
    bus_wr(8'h0e, {1'b0, pl});
    bus_wr(8'h10, 8'h83);
    cyc(140);
    peer.send(len);
    seen = 1'b0;
    repeat (len + 12)
    begin
      @(posedge clock);
      #1 seen |= ~rx_data;
    end
    chk("pulse accepted", seen, exp);
  endtask

  task t_rx;
    bus_wr(8'h08, 8'h00);
    bus_wr(8'h0c, 8'h01);
    idle_lvl <= 1'b0;
    rx_case(7'h00, 1, 1'b1);
    rx_case(7'h03, 3, 1'b0);
    rx_case(7'h03, 4, 1'b1);
    rx_case(7'h7f, 127, 1'b0);
    rx_case(7'h7f, 128, 1'b1);
    $display("test receive filter done");
  endtask

  task t_event;
    bus_wr(8'h10, 8'h00);
    idle_lvl <= 1'b1;
    event_rx <= 1'b0;
    bus_wr(8'h0c, 8'h01);
    cyc(6);
    #1 chk("pin selected", rx_data, 1);
    bus_wr(8'h0c, 8'h00);
    cyc(6);
    #1 chk("event selected", rx_data, 0);
    $display("test event input done");
  endtask

  task t_debug;
    int c;
    logic [7:0] v;
    // period of four clocks so a running prescaler is visible
    bus_wr(8'h08, 8'h03);
    bus_wr(8'h0b, 8'h00);
    debug_halt <= 1'b1;
    cyc(3);
    #1 chk("halted", halted, 1);
    ticks(c);
    chk("no ticks in halt", c, 0);
    bus_rd(8'h11, v);
    chk("halt status", v[0], 1);
    bus_wr(8'h0b, 8'h01);
    ticks(c);
    chk("ticks when run set", c, 10);
    chk("not halted", halted, 0);
    @(posedge clock);
    debug_halt <= 1'b0;
    $display("test debug halt done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(5);
    sys_rst <= 1'b0;
    t_regs;
    t_baud;
    t_ab;
    t_tx;
    t_rx;
    t_event;
    t_debug;
    complete_run;
  end

  // the whole run needs well under 20000 cycles
  initial
  begin
    #160000;
    failures++;
    complete_run;
  end
endmodule

// ---- sim/ubic_ir_peer.sv ----
// remote infrared transceiver model: sends light pulses and times received ones
module ubic_ir_peer (
  input  wire logic clock,
  input  wire logic ir_tx,
  input  wire logic idle_lvl,
  output logic      ir_rx_pin,
  output int        last_w,
  output int        n_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  int   run  = 0;

  // a light pulse is the opposite of the idle level
  assign ir_rx_pin = busy ? ~idle_lvl : idle_lvl;

  initial
  begin
    last_w = 0;
    n_pulse = 0;
  end

  always @(posedge clock)
  begin
    if (ir_tx)
      run <= run + 1;
    else if (run != 0)
    begin
      last_w  <= run;
      n_pulse <= n_pulse + 1;
      run     <= 0;
    end
  end

  task send(input int n);
    @(posedge clock);
    busy <= 1'b1;
    repeat (n) @(posedge clock);
    busy <= 1'b0;
  endtask
endmodule
